// [fthr_top.sv]
// fifo threshold configuration register with compare and wake logic
module fthr_top
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // register port, single cycle
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [5:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // fifo fill counts, same clock
   input wire logic [6:0] rx_count_in,
   input wire logic [6:0] tx_count_in,
   // power state
   input wire logic wake_in,
   // results
   output fthr_pkg::fthr_flags_t flags_out,
   output logic [6:0] rx_thr_out,
   output logic [6:0] tx_thr_out,
   output logic [1:0] near_atten_sel_out,
   output logic [5:0] near_atten_db_out,
   output fthr_pkg::fthr_test_t analog_test_out
);
   logic [7:0] fifo_threshold_config;
   wire logic sel_cfg;
   wire logic sel_t1;
   wire logic sel_t2;
   wire logic [7:0] next_rdata;
   wire logic [6:0] rx_thr;
   wire logic [6:0] tx_thr;
   wire fthr_pkg::fthr_flags_t flags;
   wire fthr_pkg::fthr_test_t next_test;
   wire logic converter_setting_retention;
   wire logic [1:0] att_sel;

   // one shared compare so read mux and write enable always agree
   function automatic logic addr_hit(input logic [5:0] addr, input logic [5:0] target);
      return addr == target;
   endfunction : addr_hit

   assign sel_cfg = addr_hit(reg_addr_in, fthr_pkg::FTHR_REG_ADDR);
   assign sel_t1 = addr_hit(reg_addr_in, fthr_pkg::FTHR_TEST_WORD_ONE_ADDR);
   assign sel_t2 = addr_hit(reg_addr_in, fthr_pkg::FTHR_TEST_WORD_TWO_ADDR);
   // test regs read reset value always; retention only steers analog
   assign next_rdata = sel_cfg ? fifo_threshold_config :
                       sel_t1 ? fthr_pkg::FTHR_T1_RESET :
                       sel_t2 ? fthr_pkg::FTHR_T2_RESET : 8'h00;
   assign converter_setting_retention = fifo_threshold_config[fthr_pkg::FTHR_RET_BIT];
   assign att_sel = fifo_threshold_config[fthr_pkg::FTHR_ATT_MSB:fthr_pkg::FTHR_ATT_LSB];
   assign next_test.test_word_one = converter_setting_retention ?
      fthr_pkg::FTHR_T1_RET1 : fthr_pkg::FTHR_T1_RET0;
   assign next_test.test_word_two = converter_setting_retention ?
      fthr_pkg::FTHR_T2_RET1 : fthr_pkg::FTHR_T2_RET0;

   fthr_compare u_cmp
   (
      .fifo_fill_threshold_in(fifo_threshold_config[fthr_pkg::FTHR_THR_MSB:fthr_pkg::FTHR_THR_LSB]),
      .rx_count_in(rx_count_in),
      .tx_count_in(tx_count_in),
      .rx_thr_out(rx_thr),
      .tx_thr_out(tx_thr),
      .flags_out(flags)
   );

   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         fifo_threshold_config <= fthr_pkg::FTHR_REG_RESET;
      end
      else if (reg_wr_in && sel_cfg)
      begin
         fifo_threshold_config <= reg_wdata_in;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
         flags_out <= '0;
         rx_thr_out <= fthr_pkg::FTHR_RX_BASE;
         tx_thr_out <= fthr_pkg::FTHR_TX_BASE;
         near_atten_sel_out <= 2'h0;
         near_atten_db_out <= fthr_pkg::FTHR_ATT_DB0;
      end
      else
      begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in)
         begin
            reg_rdata_out <= next_rdata;
         end
         flags_out <= flags;
         rx_thr_out <= rx_thr;
         tx_thr_out <= tx_thr;
         near_atten_sel_out <= att_sel;
         near_atten_db_out <= 6'(att_sel) * fthr_pkg::FTHR_ATT_STEP_DB;
      end
   end

   // loaded only on wake; holds otherwise so analog sees stable words
   always_ff @(posedge mclk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         analog_test_out <= {fthr_pkg::FTHR_T1_RET0, fthr_pkg::FTHR_T2_RET0};
      end
      else if (wake_in)
      begin
         analog_test_out <= next_test;
      end
   end

   // register port
   a_cfg_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (reg_wr_in && sel_cfg) |=> fifo_threshold_config == $past(reg_wdata_in))
      else $error("config write lost");

   a_cfg_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      !(reg_wr_in && sel_cfg) |=> $stable(fifo_threshold_config))
      else $error("config changed without write");

   a_cfg_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (reg_rd_in && sel_cfg) |=> reg_rdata_out == $past(fifo_threshold_config))
      else $error("config read wrong");

   a_rvalid_pulse: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      $past(reset_n_in) |-> reg_rvalid_out == $past(reg_rd_in))
      else $error("read valid not one cycle after read");

   a_rdata_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      !reg_rvalid_out |-> $stable(reg_rdata_out))
      else $error("read data moved without read");

   a_unmapped_zero: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (reg_rd_in && !sel_cfg && !sel_t1 && !sel_t2) |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");

   a_test_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (reg_rd_in && sel_t1) |=> reg_rdata_out == fthr_pkg::FTHR_T1_RESET)
      else $error("test read not reset value");

   a_test_word_two_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      (reg_rd_in && sel_t2) |=> reg_rdata_out == fthr_pkg::FTHR_T2_RESET)
      else $error("second test read not reset value");

   // thresholds and flags
   a_thr_tx_pair: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      7'(rx_thr_out + tx_thr_out) == 7'h41)
      else $error("thresholds not paired");

   a_rx_formula: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      rx_thr == fthr_pkg::FTHR_RX_BASE +
      7'({fifo_threshold_config[fthr_pkg::FTHR_THR_MSB:fthr_pkg::FTHR_THR_LSB], 2'h0}))
      else $error("rx threshold wrong");

   a_tx_formula: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      tx_thr == fthr_pkg::FTHR_TX_BASE -
      7'({fifo_threshold_config[fthr_pkg::FTHR_THR_MSB:fthr_pkg::FTHR_THR_LSB], 2'h0}))
      else $error("tx threshold wrong");

   a_thr_range: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      rx_thr >= 7'h04 && rx_thr <= 7'h40 && tx_thr >= 7'h01)
      else $error("threshold out of range");

   a_thr_out_lag: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      $past(reset_n_in) |-> rx_thr_out == $past(rx_thr) && tx_thr_out == $past(tx_thr))
      else $error("threshold outputs lag wrong");

   a_thr_flag_rx: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      $past(reset_n_in) |-> flags_out.rx_reached == $past(rx_count_in >= rx_thr))
      else $error("rx flag wrong");

   a_tx_flag: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      $past(reset_n_in) |-> flags_out.tx_reached == $past(tx_count_in >= tx_thr))
      else $error("tx flag wrong");

   a_flag_rx_full: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      ($past(reset_n_in) && $past(rx_count_in) == 7'h40) |-> flags_out.rx_reached)
      else $error("full rx fifo not at threshold");

   a_flag_tx_empty: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      ($past(reset_n_in) && $past(tx_count_in) == 7'h00) |-> !flags_out.tx_reached)
      else $error("empty tx fifo flagged");

   // attenuation
   a_atten_db: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      near_atten_db_out == {2'h0, near_atten_sel_out, 2'h0} +
      {3'h0, near_atten_sel_out, 1'h0})
      else $error("atten db wrong");

   a_atten_sel: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      $past(reset_n_in) |-> near_atten_sel_out == $past(att_sel))
      else $error("atten select wrong");

   a_atten_range: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      near_atten_db_out <= 6'h12)
      else $error("atten beyond top step");

   // wake words; retention only steers the analog copy
   a_wake_words: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      wake_in |=> analog_test_out.test_word_one ==
      ($past(converter_setting_retention) ? 8'h35 : 8'h31))
      else $error("wake test word wrong");

   a_wake_word_two: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      wake_in |=> analog_test_out.test_word_two ==
      ($past(converter_setting_retention) ? 8'h81 : 8'h88))
      else $error("second wake test word wrong");

   a_wake_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      !wake_in |=> $stable(analog_test_out))
      else $error("test words moved without wake");

   a_test_pairs: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
      analog_test_out == {fthr_pkg::FTHR_T1_RET0, fthr_pkg::FTHR_T2_RET0} ||
      analog_test_out == {fthr_pkg::FTHR_T1_RET1, fthr_pkg::FTHR_T2_RET1})
      else $error("test words not a known pair");

   // main scenarios
   c_rx_hit: cover property (@(posedge mclk_in) flags_out.rx_reached);
   c_tx_hit: cover property (@(posedge mclk_in) flags_out.tx_reached);
   c_wake_ret1: cover property (@(posedge mclk_in) wake_in && converter_setting_retention);
   c_max_thr: cover property (@(posedge mclk_in) rx_thr == 7'h40);
   c_test_read: cover property (@(posedge mclk_in) reg_rd_in && sel_t1);
endmodule : fthr_top

// [fthr_pkg.sv]
// package for the fifo threshold configuration block
// Contract
// - threshold field sets paired rx/tx thresholds
// - threshold reached when count at least threshold
// - wake loads test words chosen by retention
// - test register reads keep reset values
// - attenuation bits 5:4 select 0/6/12/18 dB
// - field layout, reset values, config register read/write, test registers ignore writes
package fthr_pkg;
   localparam logic [5:0] FTHR_REG_ADDR = 6'h03;
   localparam logic [5:0] FTHR_TEST_WORD_TWO_ADDR = 6'h2C;
   localparam logic [5:0] FTHR_TEST_WORD_ONE_ADDR = 6'h2D;
   localparam int FTHR_THR_LSB = 0;
   localparam int FTHR_THR_MSB = 3;
   localparam int FTHR_ATT_LSB = 4;
   localparam int FTHR_ATT_MSB = 5;
   localparam int FTHR_RET_BIT = 6;
   localparam logic [7:0] FTHR_REG_RESET = 8'h07;
   localparam logic [6:0] FTHR_RX_BASE = 7'h04;
   localparam logic [6:0] FTHR_TX_BASE = 7'h3D;
   localparam logic [6:0] FTHR_STEP = 7'h04;
   // retention 0 and 1 test word pairs
   localparam logic [7:0] FTHR_T1_RET0 = 8'h31;
   localparam logic [7:0] FTHR_T2_RET0 = 8'h88;
   localparam logic [7:0] FTHR_T1_RET1 = 8'h35;
   localparam logic [7:0] FTHR_T2_RET1 = 8'h81;
   // reset values seen by register reads; same as the retention 0 pair
   localparam logic [7:0] FTHR_T1_RESET = 8'h31;
   localparam logic [7:0] FTHR_T2_RESET = 8'h88;
   localparam logic [5:0] FTHR_ATT_DB0 = 6'h00;
   localparam logic [5:0] FTHR_ATT_STEP_DB = 6'h06;
   typedef struct packed {
      logic rx_reached;
      logic tx_reached;
   } fthr_flags_t;
   typedef struct packed {
      logic [7:0] test_word_one;
      logic [7:0] test_word_two;
   } fthr_test_t;
endpackage : fthr_pkg

// [fthr_compare.sv]
// threshold decode and fill comparison
module fthr_compare
(
   // setting
   input wire logic [3:0] fifo_fill_threshold_in,
   // fill counts
   input wire logic [6:0] rx_count_in,
   input wire logic [6:0] tx_count_in,
   // results
   output logic [6:0] rx_thr_out,
   output logic [6:0] tx_thr_out,
   output fthr_pkg::fthr_flags_t flags_out
);
   wire logic [6:0] step_amt;
   assign step_amt = 7'(fifo_fill_threshold_in) * fthr_pkg::FTHR_STEP;
   assign rx_thr_out = fthr_pkg::FTHR_RX_BASE + step_amt;
   assign tx_thr_out = fthr_pkg::FTHR_TX_BASE - step_amt;
   assign flags_out.rx_reached = rx_count_in >= rx_thr_out;
   assign flags_out.tx_reached = tx_count_in >= tx_thr_out;
endmodule : fthr_compare

// [fthr_host.sv]
// host model on the register port
module fthr_host
(
   // clock
   input wire logic mclk_in,
   // register port
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [5:0] reg_addr_out,
   output logic [7:0] reg_wdata_out,
   input wire logic [7:0] reg_rdata_in,
   input wire logic reg_rvalid_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = 6'h3F;
      reg_wdata_out = 8'hA5;
   end
   // idle bus shows inverted values so stale data cannot pass
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      @(negedge mclk_in);
      reg_addr_out = a;
      reg_wdata_out = v;
      reg_wr_out = 1'b1;
      @(negedge mclk_in);
      reg_wr_out = 1'b0;
      reg_addr_out = ~a;
      reg_wdata_out = ~v;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] v);
      @(negedge mclk_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge mclk_in);
      // answer stands only until the next edge, so take it before release
      v = reg_rvalid_in ? reg_rdata_in : 8'hXX;
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
   endtask : rd
endmodule : fthr_host

// [testbench.sv]
// self-checking bench for the fifo threshold block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, wr, rd, rvalid, wake;
   logic [5:0] addr, adb;
   logic [7:0] wdata, rdata, d, v;
   logic [6:0] rxc, txc, rxt, txt, ex_rx, ex_tx;
   logic [1:0] asel;
   logic [3:0] sv;
   fthr_pkg::fthr_flags_t flags;
   fthr_pkg::fthr_test_t tw;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   fthr_top i_fthr_top (.mclk_in(mclk), .reset_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .rx_count_in(rxc), .tx_count_in(txc), .wake_in(wake), .flags_out(flags),
      .rx_thr_out(rxt), .tx_thr_out(txt), .near_atten_sel_out(asel),
      .near_atten_db_out(adb), .analog_test_out(tw));
   fthr_host i_fthr_host (.mclk_in(mclk), .reg_wr_out(wr), .reg_rd_out(rd),
      .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // whole run needs well under 1000 cycles
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_total++;
         give_verdict();
      end
   end
   initial
   begin
      rst_n = 1'b0;
      wake = 1'b0;
      rxc = 7'h00;
      txc = 7'h00;
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      i_fthr_host.rd(fthr_pkg::FTHR_REG_ADDR, d);
      chk(d, 8'h07);
      chk({1'b0, rxt}, 8'h20);
      chk({1'b0, txt}, 8'h21);
      chk({6'h00, asel}, 8'h00);
      $display("reset test done");
      for (int s = 0; s < 16; s++)
      begin
         sv = 4'(s);
         v = {sv[3], 1'b0, sv[1:0], sv};
         ex_rx = 7'(4 * (s + 1));
         ex_tx = 7'(61 - 4 * s);
         i_fthr_host.wr(fthr_pkg::FTHR_REG_ADDR, v);
         @(negedge mclk);
         chk({1'b0, rxt}, {1'b0, ex_rx});
         chk({1'b0, txt}, {1'b0, ex_tx});
         chk({6'h00, asel}, {6'h00, sv[1:0]});
         chk({2'h0, adb}, 8'(6 * sv[1:0]));
         rxc = ex_rx - 7'h01;
         txc = ex_tx - 7'h01;
         repeat (2) @(negedge mclk);
         chk({6'h00, flags}, 8'h00);
         rxc = ex_rx;
         txc = ex_tx;
         repeat (2) @(negedge mclk);
         chk({6'h00, flags}, 8'h03);
         // counts above the threshold must also count as reached
         rxc = 7'h40;
         txc = 7'h40;
         repeat (2) @(negedge mclk);
         chk({6'h00, flags}, 8'h03);
         i_fthr_host.rd(fthr_pkg::FTHR_REG_ADDR, d);
         chk(d, v);
      end
      $display("threshold test done");
      for (int r = 1; r >= 0; r--)
      begin
         i_fthr_host.wr(fthr_pkg::FTHR_REG_ADDR, {1'b0, 1'(r), 6'h07});
         wake = 1'b1;
         @(negedge mclk);
         wake = 1'b0;
         @(negedge mclk);
         chk(tw.test_word_one, r ? 8'h35 : 8'h31);
         chk(tw.test_word_two, r ? 8'h81 : 8'h88);
         i_fthr_host.rd(fthr_pkg::FTHR_TEST_WORD_ONE_ADDR, d);
         chk(d, 8'h31);
         i_fthr_host.rd(fthr_pkg::FTHR_TEST_WORD_TWO_ADDR, d);
         chk(d, 8'h88);
      end
      // writes elsewhere must leave the config and test reads alone
      i_fthr_host.wr(fthr_pkg::FTHR_TEST_WORD_ONE_ADDR, 8'h00);
      i_fthr_host.rd(fthr_pkg::FTHR_REG_ADDR, d);
      chk(d, 8'h07);
      i_fthr_host.rd(fthr_pkg::FTHR_TEST_WORD_ONE_ADDR, d);
      chk(d, 8'h31);
      i_fthr_host.rd(6'h10, d);
      chk(d, 8'h00);
      $display("wake test done");
      // second reset in mid-run after config and words were changed
      i_fthr_host.wr(fthr_pkg::FTHR_REG_ADDR, 8'hC9);
      wake = 1'b1;
      @(negedge mclk);
      wake = 1'b0;
      rxc = 7'h40;
      txc = 7'h40;
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      chk({1'b0, rxt}, 8'h20);
      chk({6'h00, flags}, 8'h03);
      i_fthr_host.rd(fthr_pkg::FTHR_REG_ADDR, d);
      chk(d, 8'h07);
      $display("mid-run reset test done");
      give_verdict();
   end
endmodule : testbench
